// file: hdl/nvhs_pkg.sv
// Shared constants, command codes and helpers for the save handoff link.
// Assumes both ends run on one mclk and are joined by nvhs_if.
package nvhs_pkg;
  localparam int          ROW_W     = 16;
  localparam int          COL_W     = 10;
  localparam int          BG_W      = 2;
  localparam int          BA_W      = 2;
  localparam int          CB_W      = 8;
  localparam int          DQ_W      = 72;
  localparam int          CL_W      = 5;
  localparam int          IDX_W     = BG_W + BA_W + ROW_W + COL_W;
  localparam logic [3:0]  BEATS_BL8 = 4'h8;
  localparam logic [3:0]  BEATS_BC4 = 4'h4;
  localparam int          CL_FAST   = 17;
  localparam int          CL_SLOW   = 15;
  localparam int          TCK_FAST_PS = 830;
  localparam int          TCK_SLOW_PS = 930;
  // Mode word layout carried on the address bus by a mode set
  localparam int          MR_BM_LSB = 0;
  localparam int          MR_CL_LSB = 2;
  localparam logic [1:0]  RST_BM    = 2'h0;
  localparam logic [4:0]  RST_CL    = 5'h11;
  localparam int          DRST_CYC  = 8;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_MRS, CMD_ACT, CMD_WR, CMD_RD, CMD_SRE, CMD_SRX
  } nvhs_cmd_e;

  typedef enum logic [1:0] {BM_BL8, BM_BC4, BM_OTF} nvhs_bm_e;

  // Beats in one burst; on-the-fly picks per command
  function automatic logic [3:0] nvhs_beats(input nvhs_bm_e bm, input logic otf_bc4);
    logic [3:0] b;
    b = BEATS_BL8;
    if (bm == BM_BC4 || (bm == BM_OTF && otf_bc4)) begin
      b = BEATS_BC4;
    end
    return b;
  endfunction : nvhs_beats

  // Linear word index from bank group, bank, row and column
  function automatic logic [IDX_W-1:0] nvhs_idx(input logic [BG_W-1:0] bg,
      input logic [BA_W-1:0] ba, input logic [ROW_W-1:0] row, input logic [COL_W-1:0] col);
    return {bg, ba, row, col};
  endfunction : nvhs_idx
endpackage : nvhs_pkg

// file: hdl/nvhs_if.sv
// Connector between host controller end and module controller end.
// Assumes a single mclk shared by both ends; no tristate pins.
`timescale 1ns/1ps
`default_nettype none
interface nvhs_if;
  logic                              cke0;
  logic                              dram_rst_n;
  logic                              save_n;
  logic                              cs0_n;
  nvhs_pkg::nvhs_cmd_e               cmd;
  logic [nvhs_pkg::BG_W-1:0]         bg;
  logic [nvhs_pkg::BA_W-1:0]         ba;
  logic [nvhs_pkg::ROW_W-1:0]        addr;
  logic                              otf_bc4;
  logic [nvhs_pkg::DQ_W-1:0]         wdq;
  logic                              wdq_vld;
  logic [nvhs_pkg::DQ_W-1:0]         rdq;
  logic                              rdq_vld;
  logic                              nv_busy;

  modport host (output cke0, dram_rst_n, save_n, cs0_n, cmd, bg, ba, addr, otf_bc4,
                output wdq, wdq_vld, input rdq, rdq_vld, nv_busy);
  modport dev  (input cke0, dram_rst_n, save_n, cs0_n, cmd, bg, ba, addr, otf_bc4,
                input wdq, wdq_vld, output rdq, rdq_vld, nv_busy);
endinterface : nvhs_if
`default_nettype wire

// file: hdl/nvhs_dev.sv
// Module controller end: small DRAM image, save trigger and flash copy.
// Assumes the host finishes traffic and enters self refresh before saving.
`timescale 1ns/1ps
`default_nettype none
module nvhs_dev #(
  parameter int MEM_AW = 6
) (
  input  wire logic mclk,
  input  wire logic arst_n,
  nvhs_if.dev       lnk,
  input  wire logic smb_save,
  input  wire logic cke_trig_en,
  input  wire logic restore_req,
  output logic      saved,
  output logic      backup_active
);
  typedef enum logic [2:0] {D_RUN, D_SR, D_SAVE, D_OFF, D_REST} nvhs_dst_e;
  typedef struct packed {
    nvhs_dst_e              st;
    nvhs_pkg::nvhs_bm_e     bm;
    logic [4:0]             cl;
    logic [nvhs_pkg::ROW_W-1:0] row;
    logic [MEM_AW-1:0]      base;
    logic [4:0]             cl_cnt;
    logic                   rd_pend;
    logic                   rd_act;
    logic                   wr_act;
    logic [3:0]             beat;
    logic [3:0]             nbeats;
    logic [MEM_AW-1:0]      ptr;
    logic                   save_n_d;
    logic                   cke_d;
    logic                   saved;
    logic [nvhs_pkg::DQ_W-1:0] rdq;
    logic                   rdq_vld;
  } nvhs_dstate_s;

  localparam logic [MEM_AW-1:0] PTR_LAST = {MEM_AW{1'b1}};

  nvhs_dstate_s q_ff, nxt_q;
  logic [nvhs_pkg::DQ_W-1:0] dram_mem [2**MEM_AW];
  logic [nvhs_pkg::DQ_W-1:0] flash_mem [2**MEM_AW];
  logic                      mem_we;
  logic                      fl_we;
  logic [MEM_AW-1:0]         mem_wa;
  logic [nvhs_pkg::DQ_W-1:0] mem_wd;
  logic                      trig;
  logic [nvhs_pkg::IDX_W-1:0] idx;

  // Any of the three save sources starts a backup
  assign trig = (q_ff.save_n_d && !lnk.save_n) || smb_save
              || (cke_trig_en && q_ff.cke_d && !lnk.cke0);
  assign idx  = nvhs_pkg::nvhs_idx(lnk.bg, lnk.ba, q_ff.row, lnk.addr[nvhs_pkg::COL_W-1:0]);

  // Next state
  always_comb begin
    nxt_q          = q_ff;
    nxt_q.rdq_vld  = 1'b0;
    nxt_q.save_n_d = lnk.save_n;
    nxt_q.cke_d    = lnk.cke0;
    mem_we         = 1'b0;
    fl_we          = 1'b0;
    mem_wa         = q_ff.base + MEM_AW'(q_ff.beat);
    mem_wd         = lnk.wdq;
    case (q_ff.st)
      D_RUN, D_SR: begin
        // Commands count only while clocked and selected
        if (q_ff.st == D_RUN && lnk.cke0 && !lnk.cs0_n) begin
          case (lnk.cmd)
            nvhs_pkg::CMD_MRS: begin
              nxt_q.bm = nvhs_pkg::nvhs_bm_e'(lnk.addr[nvhs_pkg::MR_BM_LSB +: 2]);
              nxt_q.cl = lnk.addr[nvhs_pkg::MR_CL_LSB +: 5];
            end
            nvhs_pkg::CMD_ACT: nxt_q.row = lnk.addr;
            nvhs_pkg::CMD_WR, nvhs_pkg::CMD_RD: begin
              nxt_q.base   = idx[MEM_AW-1:0];
              nxt_q.beat   = 4'h0;
              nxt_q.nbeats = nvhs_pkg::nvhs_beats(q_ff.bm, lnk.otf_bc4);
              nxt_q.wr_act = (lnk.cmd == nvhs_pkg::CMD_WR);
              nxt_q.rd_pend = (lnk.cmd == nvhs_pkg::CMD_RD);
              nxt_q.cl_cnt = q_ff.cl - 5'h1;
            end
            nvhs_pkg::CMD_SRE: nxt_q.st = D_SR;
            default: ;
          endcase
        end
        if (q_ff.st == D_SR && lnk.cke0) begin
          nxt_q.st = D_RUN;
        end
        // Write beats land one per valid cycle, full 72-bit word with check bits
        if (q_ff.wr_act && lnk.wdq_vld) begin
          mem_we     = 1'b1;
          nxt_q.beat = q_ff.beat + 4'h1;
          nxt_q.wr_act = (q_ff.beat != q_ff.nbeats - 4'h1);
        end
        if (q_ff.rd_pend) begin
          nxt_q.cl_cnt = q_ff.cl_cnt - 5'h1;
          if (q_ff.cl_cnt <= 5'h1) begin
            nxt_q.rd_pend = 1'b0;
            nxt_q.rd_act  = 1'b1;
          end
        end
        if (q_ff.rd_act) begin
          nxt_q.rdq     = dram_mem[mem_wa];
          nxt_q.rdq_vld = 1'b1;
          nxt_q.beat    = q_ff.beat + 4'h1;
          nxt_q.rd_act  = (q_ff.beat != q_ff.nbeats - 4'h1);
        end
        if (trig) begin
          nxt_q.st      = D_SAVE;
          nxt_q.ptr     = '0;
          nxt_q.saved   = 1'b0;
          nxt_q.rd_pend = 1'b0;
          nxt_q.rd_act  = 1'b0;
          nxt_q.wr_act  = 1'b0;
        end
      end
      // Whole image goes to flash, one word per cycle, then power down
      D_SAVE: begin
        fl_we     = 1'b1;
        nxt_q.ptr = q_ff.ptr + MEM_AW'(1);
        if (q_ff.ptr == PTR_LAST) begin
          nxt_q.st    = D_OFF;
          nxt_q.saved = 1'b1;
        end
      end
      D_OFF: begin
        if (restore_req) begin
          nxt_q.st  = D_REST;
          nxt_q.ptr = '0;
        end
      end
      // Restore refills DRAM and hands it back still in self refresh
      D_REST: begin
        mem_we    = 1'b1;
        mem_wa    = q_ff.ptr;
        mem_wd    = flash_mem[q_ff.ptr];
        nxt_q.ptr = q_ff.ptr + MEM_AW'(1);
        if (q_ff.ptr == PTR_LAST) begin
          nxt_q.st = D_SR;
        end
      end
      default: nxt_q.st = D_RUN;
    endcase
    // A DRAM reset outside save and power-down returns the state machine to D_RUN and burst mode to RST_BM; DRAM contents are kept
    if (!lnk.dram_rst_n && q_ff.st != D_SAVE && q_ff.st != D_OFF) begin
      nxt_q.st      = D_RUN;
      nxt_q.bm      = nvhs_pkg::nvhs_bm_e'(nvhs_pkg::RST_BM);
      nxt_q.rd_pend = 1'b0;
      nxt_q.rd_act  = 1'b0;
      nxt_q.wr_act  = 1'b0;
    end
  end

  // State register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q_ff          <= '0;
      q_ff.st       <= D_RUN;
      q_ff.cl       <= nvhs_pkg::RST_CL;
      q_ff.save_n_d <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Arrays carry no reset; contents are data, not control
  always_ff @(posedge mclk) begin
    if (mem_we) begin
      dram_mem[mem_wa] <= mem_wd;
    end
    if (fl_we) begin
      flash_mem[q_ff.ptr] <= dram_mem[q_ff.ptr];
    end
  end

  assign lnk.rdq       = q_ff.rdq;
  assign lnk.rdq_vld   = q_ff.rdq_vld;
  assign lnk.nv_busy   = (q_ff.st == D_SAVE) || (q_ff.st == D_OFF) || (q_ff.st == D_REST);
  assign saved         = q_ff.saved;
  assign backup_active = (q_ff.st == D_SAVE);
endmodule : nvhs_dev
`default_nettype wire

// file: hdl/nvhs_host.sv
// Host memory controller end: init, simple access, power-fail handoff.
// Assumes pwr_warn comes from a supply monitor early enough to drain.
`timescale 1ns/1ps
`default_nettype none
module nvhs_host #(
  parameter int CL = nvhs_pkg::CL_FAST
) (
  input  wire logic                        mclk,
  input  wire logic                        arst_n,
  nvhs_if.host                             lnk,
  input  wire logic                        pwr_warn,
  input  wire logic [1:0]                  burst_cfg,
  input  wire logic                        req_vld,
  output logic                             req_rdy,
  input  wire logic                        req_wr,
  input  wire logic                        req_bc4,
  input  wire logic [nvhs_pkg::BG_W-1:0]   req_bg,
  input  wire logic [nvhs_pkg::BA_W-1:0]   req_ba,
  input  wire logic [nvhs_pkg::ROW_W-1:0]  req_row,
  input  wire logic [nvhs_pkg::COL_W-1:0]  req_col,
  input  wire logic [nvhs_pkg::DQ_W-1:0]   wr_data,
  output logic                             wr_pull,
  output logic [nvhs_pkg::DQ_W-1:0]        rd_data,
  output logic                             rd_vld,
  output logic                             handed
);
  typedef enum logic [3:0] {
    H_RST, H_MRS, H_IDLE, H_CMD, H_WR, H_RD, H_SRE, H_SAVE, H_HAND, H_SRX
  } nvhs_hst_e;
  typedef struct packed {
    nvhs_hst_e                  st;
    logic [3:0]                 cnt;
    logic                       cke0;
    logic                       dram_rst_n;
    logic                       save_n;
    logic                       cs0_n;
    nvhs_pkg::nvhs_cmd_e        cmd;
    logic [nvhs_pkg::BG_W-1:0]  bg;
    logic [nvhs_pkg::BA_W-1:0]  ba;
    logic [nvhs_pkg::ROW_W-1:0] addr;
    logic                       otf_bc4;
    logic [nvhs_pkg::COL_W-1:0] col;
    logic                       wr;
    logic [3:0]                 beat;
    logic [3:0]                 nbeats;
    logic [nvhs_pkg::DQ_W-1:0]  wdq;
    logic                       wdq_vld;
    logic [nvhs_pkg::DQ_W-1:0]  rdata;
    logic                       rvld;
    logic                       handed;
  } nvhs_hstate_s;

  localparam logic [3:0] RST_LAST = 4'(nvhs_pkg::DRST_CYC - 1);
  localparam logic [4:0] CL_CODE  = 5'(CL);

  nvhs_hstate_s q_ff, nxt_q;

  // New work is refused once a power warning is up
  assign req_rdy = (q_ff.st == H_IDLE) && !pwr_warn;
  assign wr_pull = (q_ff.st == H_WR);

  // Next state
  always_comb begin
    nxt_q         = q_ff;
    nxt_q.cs0_n   = 1'b1;
    nxt_q.cmd     = nvhs_pkg::CMD_NOP;
    nxt_q.wdq_vld = 1'b0;
    nxt_q.rvld    = 1'b0;
    case (q_ff.st)
      // DRAM reset only at power-up, never again after a restore
      H_RST: begin
        nxt_q.cnt = q_ff.cnt + 4'h1;
        if (q_ff.cnt == RST_LAST) begin
          nxt_q.dram_rst_n = 1'b1;
          nxt_q.cke0       = 1'b1;
          nxt_q.st         = H_MRS;
        end
      end
      // Mode set carries burst choice and CAS latency
      H_MRS: begin
        nxt_q.cs0_n = 1'b0;
        nxt_q.cmd   = nvhs_pkg::CMD_MRS;
        nxt_q.addr  = '0;
        nxt_q.addr[nvhs_pkg::MR_BM_LSB +: 2] = burst_cfg;
        nxt_q.addr[nvhs_pkg::MR_CL_LSB +: 5] = CL_CODE;
        nxt_q.nbeats = nvhs_pkg::nvhs_beats(nvhs_pkg::nvhs_bm_e'(burst_cfg), 1'b0);
        nxt_q.wr     = burst_cfg == 2'(nvhs_pkg::BM_OTF);
        nxt_q.st     = H_IDLE;
      end
      H_IDLE: begin
        if (pwr_warn) begin
          // Nothing is in flight here, so the DRAM is quiet
          nxt_q.st = H_SRE;
        end else if (req_vld) begin
          nxt_q.cs0_n   = 1'b0;
          nxt_q.cmd     = nvhs_pkg::CMD_ACT;
          nxt_q.bg      = req_bg;
          nxt_q.ba      = req_ba;
          nxt_q.addr    = req_row;
          nxt_q.col     = req_col;
          nxt_q.otf_bc4 = req_bc4;
          nxt_q.cnt     = {3'h0, req_wr};
          nxt_q.st      = H_CMD;
        end
      end
      H_CMD: begin
        nxt_q.cs0_n = 1'b0;
        nxt_q.cmd   = q_ff.cnt[0] ? nvhs_pkg::CMD_WR : nvhs_pkg::CMD_RD;
        nxt_q.addr  = {{(nvhs_pkg::ROW_W-nvhs_pkg::COL_W){1'b0}}, q_ff.col};
        nxt_q.beat  = 4'h0;
        // Fixed modes ignore the per-command bit; on the fly uses it
        if (q_ff.wr) begin
          nxt_q.nbeats = nvhs_pkg::nvhs_beats(nvhs_pkg::BM_OTF, q_ff.otf_bc4);
        end
        nxt_q.st = q_ff.cnt[0] ? H_WR : H_RD;
      end
      // One 72-bit word per beat, check bits supplied by the user side
      H_WR: begin
        nxt_q.wdq     = wr_data;
        nxt_q.wdq_vld = 1'b1;
        nxt_q.beat    = q_ff.beat + 4'h1;
        if (q_ff.beat == q_ff.nbeats - 4'h1) begin
          nxt_q.st = H_IDLE;
        end
      end
      H_RD: begin
        if (lnk.rdq_vld) begin
          nxt_q.rdata = lnk.rdq;
          nxt_q.rvld  = 1'b1;
          nxt_q.beat  = q_ff.beat + 4'h1;
          if (q_ff.beat == q_ff.nbeats - 4'h1) begin
            nxt_q.st = H_IDLE;
          end
        end
      end
      H_SRE: begin
        nxt_q.cs0_n = 1'b0;
        nxt_q.cmd   = nvhs_pkg::CMD_SRE;
        nxt_q.cke0  = 1'b0;
        nxt_q.st    = H_SAVE;
      end
      // Save request only after self refresh is entered
      H_SAVE: begin
        nxt_q.save_n = 1'b0;
        if (lnk.nv_busy) begin
          nxt_q.save_n = 1'b1;
          nxt_q.handed = 1'b1;
          nxt_q.st     = H_HAND;
        end
      end
      // Module owns the DRAM; CKE0 held low and reset held off
      H_HAND: begin
        nxt_q.cke0 = 1'b0;
        if (!lnk.nv_busy) begin
          nxt_q.st = H_SRX;
        end
      end
      // Leave self refresh before any normal access
      H_SRX: begin
        nxt_q.cke0   = 1'b1;
        nxt_q.cs0_n  = 1'b0;
        nxt_q.cmd    = nvhs_pkg::CMD_SRX;
        nxt_q.handed = 1'b0;
        nxt_q.st     = H_IDLE;
      end
      default: nxt_q.st = H_RST;
    endcase
  end

  // State register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q_ff        <= '0;
      q_ff.st     <= H_RST;
      q_ff.save_n <= 1'b1;
      q_ff.cs0_n  <= 1'b1;
      q_ff.cmd    <= nvhs_pkg::CMD_NOP;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign lnk.cke0       = q_ff.cke0;
  assign lnk.dram_rst_n = q_ff.dram_rst_n;
  assign lnk.save_n     = q_ff.save_n;
  assign lnk.cs0_n      = q_ff.cs0_n;
  assign lnk.cmd        = q_ff.cmd;
  assign lnk.bg         = q_ff.bg;
  assign lnk.ba         = q_ff.ba;
  assign lnk.addr       = q_ff.addr;
  assign lnk.otf_bc4    = q_ff.otf_bc4;
  assign lnk.wdq        = q_ff.wdq;
  assign lnk.wdq_vld    = q_ff.wdq_vld;
  assign rd_data        = q_ff.rdata;
  assign rd_vld         = q_ff.rvld;
  assign handed         = q_ff.handed;
endmodule : nvhs_host
`default_nettype wire

// file: tb/nvhs_props.sv
// Checker for the save handoff link between the host end and the module end.
// Assumes one mclk and one arst_n for both ends; the bench instantiates it.
`timescale 1ns/1ps
`default_nettype none
module nvhs_props (
  input wire logic                mclk,
  input wire logic                arst_n,
  input wire logic                cke0,
  input wire logic                dram_rst_n,
  input wire logic                save_n,
  input wire logic                cs0_n,
  input wire nvhs_pkg::nvhs_cmd_e cmd,
  input wire logic                wdq_vld,
  input wire logic                rdq_vld,
  input wire logic                nv_busy
);
  logic [3:0] wrun_ff;
  logic [3:0] rrun_ff;
  logic       up_ff;

  // The beat is registered, so it is sampled one edge after the CAS latency count
  localparam int RD_LAT = nvhs_pkg::CL_FAST + 1;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // Beat run lengths, and a flag once the DRAM has left its reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wrun_ff <= 4'h0;
      rrun_ff <= 4'h0;
      up_ff   <= 1'b0;
    end else begin
      wrun_ff <= wdq_vld ? wrun_ff + 4'h1 : 4'h0;
      rrun_ff <= rdq_vld ? rrun_ff + 4'h1 : 4'h0;
      up_ff   <= up_ff | dram_rst_n;
    end
  end

  // Handoff sequencing and access rules on the wire
  sr_cke_low_a: assert property (!cs0_n && cmd == nvhs_pkg::CMD_SRE |-> !cke0)
    else $error("self refresh entry without clock enable low");
  save_in_sr_a: assert property (!save_n |-> !cke0 && !$past(cke0))
    else $error("save request outside self refresh");
  busy_on_save_a: assert property ($fell(save_n) |-> ##[0:2] nv_busy)
    else $error("save request not taken by module end");
  hand_quiet_a: assert property (nv_busy |-> cs0_n || cke0)
    else $error("command issued while module owns the DRAM");
  no_dram_reset_a: assert property (up_ff |-> dram_rst_n)
    else $error("DRAM reset pulsed after init");
  srx_on_return_a: assert property ($fell(nv_busy) |->
      ##[0:2] (!cs0_n && cmd == nvhs_pkg::CMD_SRX && cke0))
    else $error("no self refresh exit after return");
  quiet_in_sr_a: assert property (!cke0 && !$past(cke0) |-> cs0_n)
    else $error("command while in self refresh");
  act_first_a: assert property (!cs0_n && cmd inside {nvhs_pkg::CMD_WR, nvhs_pkg::CMD_RD}
      |-> !$past(cs0_n) && $past(cmd) == nvhs_pkg::CMD_ACT)
    else $error("access without row open");
  rd_latency_a: assert property (!cs0_n && cke0 && cmd == nvhs_pkg::CMD_RD
      |-> ##RD_LAT $rose(rdq_vld))
    else $error("read data not at CAS latency");
  wr_burst_a: assert property ($fell(wdq_vld) |-> wrun_ff == 4'h4 || wrun_ff == 4'h8)
    else $error("write burst length wrong");
  rd_burst_a: assert property ($fell(rdq_vld) |-> rrun_ff == 4'h4 || rrun_ff == 4'h8)
    else $error("read burst length wrong");

  // Main scenarios reached
  cover property ($fell(save_n));
  cover property ($fell(nv_busy));
  cover property ($fell(rdq_vld) && rrun_ff == 4'h4);
endmodule : nvhs_props
`default_nettype wire

// file: tb/nvhs_bench.sv
// Bench joining host end and module end: access, power fail, save, restore.
// Assumes the package and interface are compiled first; one 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module nvhs_bench;
  logic        mclk, arst_n, pwr_warn, req_vld, req_wr, req_bc4;
  logic        smb_save, cke_trig_en, restore_req;
  logic        req_rdy, wr_pull, rd_vld, handed, saved, backup_active;
  logic [1:0]  burst_cfg, req_bg, req_ba;
  logic [15:0] req_row;
  logic [9:0]  req_col;
  logic [71:0] wr_data, rd_data;
  logic [71:0] rbuf [0:7];
  int          nw, nr, mark, num_errors, compares;

  nvhs_if lnk();
  nvhs_host nvhs_host_inst (.mclk, .arst_n, .lnk, .pwr_warn, .burst_cfg, .req_vld, .req_rdy,
    .req_wr, .req_bc4, .req_bg, .req_ba, .req_row, .req_col, .wr_data, .wr_pull, .rd_data,
    .rd_vld, .handed);
  nvhs_dev nvhs_dev_inst (.mclk, .arst_n, .lnk, .smb_save, .cke_trig_en, .restore_req,
    .saved, .backup_active);
  nvhs_props nvhs_props_inst (.mclk, .arst_n, .cke0(lnk.cke0), .dram_rst_n(lnk.dram_rst_n),
    .save_n(lnk.save_n), .cs0_n(lnk.cs0_n), .cmd(lnk.cmd), .wdq_vld(lnk.wdq_vld),
    .rdq_vld(lnk.rdq_vld), .nv_busy(lnk.nv_busy));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Beat word: top byte stands in for the check bits
  function automatic logic [71:0] pat(input int m, input int b);
    return {8'(m * 16 + b), 64'hC3A5_0F1E_2D3C_4B5A ^ 64'(b * 7)};
  endfunction : pat

  function automatic logic sig(input int s);
    case (s)
      0: return req_rdy;
      1: return handed;
      2: return saved;
      default: return backup_active;
    endcase
  endfunction : sig

  // Bounded wait at falling edges, where outputs have settled
  task automatic wt(input int s, input logic v, input int n);
    for (int i = 0; i < n && sig(s) !== v; i++) @(negedge mclk);
  endtask : wt

  task automatic chk_data(input string nm, input logic [71:0] e, input logic [71:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_data

  task automatic chk_flag(input string nm, input logic e, input logic g);
    chk_data(nm, 72'(e), 72'(g));
  endtask : chk_flag

  task automatic chk_cnt(input string nm, input int e, input int g);
    chk_data(nm, 72'(e), 72'(g));
  endtask : chk_cnt

  // Burst choice goes in with reset so the mode set after release picks it up
  task automatic rst(input logic [1:0] bc);
    @(posedge mclk);
    arst_n    <= 1'b0;
    burst_cfg <= bc;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    @(negedge mclk);
    wt(0, 1'b1, 40);
  endtask : rst

  // One user access held until taken, then run to idle and checked
  task automatic xfer(input logic w, input logic b4, input int m, input int n);
    @(posedge mclk);
    req_vld <= 1'b1;
    req_wr  <= w;
    req_bc4 <= b4;
    wr_data <= pat(m, 0);
    mark = m;
    nw = 0;
    nr = 0;
    @(negedge mclk);
    wt(0, 1'b1, 40);
    @(posedge mclk);
    req_vld <= 1'b0;
    @(negedge mclk);
    wt(0, 1'b1, 80);
    @(negedge mclk);
    chk_cnt(w ? "write beats" : "read beats", n, w ? nw : nr);
    for (int b = 0; b < n && !w; b++) chk_data("read data", pat(m, b), rbuf[b]);
  endtask : xfer

  // Write beats follow the pull strobe; read beats are captured per pulse
  always @(posedge mclk) begin
    if (wr_pull) begin
      nw = nw + 1;
      wr_data <= pat(mark, nw);
    end
    if (rd_vld && nr < 8) begin
      rbuf[nr] = rd_data;
      nr = nr + 1;
    end
  end

  task automatic finish_test();
    $display("Comparisons %0d, errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    finish_test();
  end

  initial begin
    {arst_n, pwr_warn, req_vld, req_wr, req_bc4, smb_save, cke_trig_en, restore_req} = '0;
    {burst_cfg, req_bg, req_ba, wr_data} = {2'h0, 2'h3, 2'h2, 72'h0};
    req_row = 16'hBEEF;
    req_col = 10'h008;
    num_errors = 0;
    compares = 0;
    // Fixed long, fixed chop, then on the fly with the chop bit set
    for (int md = 0; md < 3; md++) begin
      rst(2'(md));
      xfer(1'b1, 1'b1, md, md == 0 ? 8 : 4);
      xfer(1'b0, 1'b1, md, md == 0 ? 8 : 4);
    end
    xfer(1'b1, 1'b0, 3, 8);
    // Power fail: self refresh, save, restore, then data must survive
    @(posedge mclk);
    cke_trig_en <= 1'b1;
    pwr_warn <= 1'b1;
    @(negedge mclk);
    chk_flag("request ready", 1'b0, req_rdy);
    wt(1, 1'b1, 40);
    chk_flag("handed", 1'b1, handed);
    @(posedge mclk);
    pwr_warn <= 1'b0;
    @(negedge mclk);
    wt(2, 1'b1, 200);
    chk_flag("saved", 1'b1, saved);
    chk_flag("backup active", 1'b0, backup_active);
    @(posedge mclk);
    restore_req <= 1'b1;
    @(posedge mclk);
    restore_req <= 1'b0;
    @(negedge mclk);
    wt(1, 1'b0, 200);
    chk_flag("handed", 1'b0, handed);
    wt(0, 1'b1, 20);
    xfer(1'b0, 1'b0, 3, 8);
    // Save commanded over the side bus, host not involved
    rst(2'h0);
    @(posedge mclk);
    cke_trig_en <= 1'b0;
    smb_save <= 1'b1;
    @(posedge mclk);
    smb_save <= 1'b0;
    @(negedge mclk);
    wt(3, 1'b1, 5);
    chk_flag("backup active", 1'b1, backup_active);
    wt(2, 1'b1, 200);
    chk_flag("saved", 1'b1, saved);
    finish_test();
  end
endmodule : nvhs_bench
`default_nettype wire
